// ===== rtl/add_and_bitclear_exec.sv
// Decode and single-cycle execution of add, and, and bit-erase on file registers
// Functional notes
// (RQ1) Word 00 0111 dfff ffff adds accumulator to file in one cycle, sets carry, half, zero.
// (RQ2) For the add, destination bit 0 sends the sum to the accumulator and 1 back to the file.
// (RQ3) Word 00 0101 dfff ffff ands the accumulator with the file, touches only zero, one cycle.
// (RQ4) For the and, destination bit 0 sends the result to the accumulator and 1 back to the file.
// (RQ5) Word 01 00bb bfff ffff clears bit b of the file in one cycle and leaves every flag alone.
// (RQ6) A port register used as operand is read from its synchronised pin levels, not its latch.
// (RQ7) A write to the timer zero count register clears the prescaler if it is on that timer.
module add_and_bitclear_exec (
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  instr_valid_in,
  input  wire logic [13:0]           instr_word_in,
  input  wire logic [7:0]            file_rd_data_in,
  input  wire logic [7:0]            port_a_pins_in,
  input  wire logic [7:0]            port_b_pins_in,
  input  wire logic                  prescaler_on_timer_in,
  output logic      [7:0]            acc_out,
  output exec_pkg::flags_t           flags_out,
  output exec_pkg::file_wr_t         file_wr_out,
  output logic                       prescaler_clr_out,
  output logic                       done_out,
  output logic                       unsupported_out
);

  typedef struct packed {
    logic [15:0]        pin_meta;
    logic [15:0]        pin_sync;
    logic [7:0]         acc;
    exec_pkg::flags_t   flags;
    exec_pkg::file_wr_t wr;
    logic               psc_clr;
    logic               done;
    logic               unsupported;
  } state_t;

  state_t             state_ff;
  state_t             nxt_state;
  exec_pkg::decoded_t dec;
  logic [7:0]         operand;
  logic [7:0]         result;
  logic               alu_carry;
  logic               alu_half;
  logic               alu_zero;
  logic               to_file;

  assign dec = exec_pkg::decode(instr_word_in);

  // Pin level replaces the latch for port operands
  always_comb
  begin
    case (dec.addr)
      exec_pkg::PORT_A_ADDR: operand = state_ff.pin_sync[7:0];  // RQ6
      exec_pkg::PORT_B_ADDR: operand = state_ff.pin_sync[15:8]; // RQ6
      default:               operand = file_rd_data_in;
    endcase
  end

  exec_alu u_alu (
    .op_in      (dec.op),
    .acc_in     (state_ff.acc),
    .operand_in (operand),
    .bitpos_in  (dec.bitpos),
    .result_out (result),
    .carry_out  (alu_carry),
    .half_out   (alu_half),
    .zero_out   (alu_zero)
  );

  // Bit erase always rewrites the file; add and and follow the destination bit
  assign to_file = (dec.op == exec_pkg::OP_ERASE) || dec.dest; // RQ2 RQ4 RQ5

  always_comb
  begin
    nxt_state             = state_ff;
    nxt_state.pin_meta    = {port_b_pins_in, port_a_pins_in};
    nxt_state.pin_sync    = state_ff.pin_meta;
    nxt_state.wr.wr_en    = 1'h0;
    nxt_state.psc_clr     = 1'h0;
    nxt_state.done        = 1'h0;
    nxt_state.unsupported = 1'h0;
    if (instr_valid_in)
    begin
      nxt_state.done = (dec.op != exec_pkg::OP_NONE);
      case (dec.op)
        exec_pkg::OP_ADD:
        begin
          nxt_state.flags.carry            = alu_carry; // RQ1
          nxt_state.flags.half_nibble_flag = alu_half;  // RQ1
          nxt_state.flags.zero             = alu_zero;  // RQ1
        end
        exec_pkg::OP_AND:
          nxt_state.flags.zero = alu_zero; // RQ3
        exec_pkg::OP_ERASE:
          nxt_state.flags = state_ff.flags; // RQ5
        default:
          nxt_state.unsupported = 1'h1;
      endcase
      if (dec.op != exec_pkg::OP_NONE)
      begin
        if (to_file)
        begin
          nxt_state.wr.wr_en = 1'h1;
          nxt_state.wr.addr  = dec.addr;
          nxt_state.wr.data  = result;
          // Prescaler loses its count along with the timer write
          nxt_state.psc_clr  = (dec.addr == exec_pkg::TIMER_ZERO_COUNT_ADDR)
                               && prescaler_on_timer_in; // RQ7
        end
        else
        begin
          nxt_state.acc = result; // RQ2 RQ4
        end
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      state_ff                        <= '0;
      state_ff.acc                    <= exec_pkg::ACC_RESET;
      state_ff.flags.carry            <= exec_pkg::FLAG_RESET;
      state_ff.flags.half_nibble_flag <= exec_pkg::FLAG_RESET;
      state_ff.flags.zero             <= exec_pkg::FLAG_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign acc_out           = state_ff.acc;
  assign flags_out         = state_ff.flags;
  assign file_wr_out       = state_ff.wr;
  assign prescaler_clr_out = state_ff.psc_clr;
  assign done_out          = state_ff.done;
  assign unsupported_out   = state_ff.unsupported;

endmodule // add_and_bitclear_exec

// ===== rtl/exec_pkg.sv
// Shared constants, types and decode function for the add / and / bit-clear executor
package exec_pkg;

  localparam int unsigned INSTR_W = 14;
  localparam int unsigned ADDR_W  = 7;
  localparam int unsigned DATA_W  = 8;

  // Opcode fields, upper bits of the instruction word
  localparam logic [5:0] OPC_ADD_ACC  = 6'h07;
  localparam logic [5:0] OPC_AND_ACC  = 6'h05;
  localparam logic [3:0] OPC_POS_ERASE = 4'h4;

  // Field positions inside the instruction word
  localparam int unsigned DEST_BIT  = 7;
  localparam int unsigned BITPOS_LO = 7;

  // File addresses with side effects
  localparam logic [6:0] TIMER_ZERO_COUNT_ADDR = 7'h01;
  localparam logic [6:0] PORT_A_ADDR           = 7'h05;
  localparam logic [6:0] PORT_B_ADDR           = 7'h06;

  localparam logic [7:0] ACC_RESET   = 8'h00;
  localparam logic       FLAG_RESET  = 1'h0;

  typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_AND, OP_ERASE} op_t;

  typedef struct packed {
    op_t        op;
    logic [6:0] addr;
    logic       dest;
    logic [2:0] bitpos;
  } decoded_t;

  typedef struct packed {
    logic carry;
    logic half_nibble_flag;
    logic zero;
  } flags_t;

  typedef struct packed {
    logic       wr_en;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  function automatic decoded_t decode(input logic [13:0] word);
    decoded_t d;
    d.addr   = word[6:0];
    d.dest   = word[DEST_BIT];
    d.bitpos = word[BITPOS_LO+2:BITPOS_LO];
    if (word[13:8] == OPC_ADD_ACC)
      d.op = OP_ADD;
    else if (word[13:8] == OPC_AND_ACC)
      d.op = OP_AND;
    else if (word[13:10] == OPC_POS_ERASE)
      d.op = OP_ERASE;
    else
      d.op = OP_NONE;
    return d;
  endfunction

endpackage

// ===== rtl/exec_alu.sv
// Combinational datapath: add, and, single bit erase with flag results
module exec_alu (
  input  wire exec_pkg::op_t  op_in,
  input  wire logic [7:0]     acc_in,
  input  wire logic [7:0]     operand_in,
  input  wire logic [2:0]     bitpos_in,
  output logic      [7:0]     result_out,
  output logic                carry_out,
  output logic                half_out,
  output logic                zero_out
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb
  begin
    sum        = {1'h0, acc_in} + {1'h0, operand_in};
    low_sum    = {1'h0, acc_in[3:0]} + {1'h0, operand_in[3:0]};
    carry_out  = 1'h0;
    half_out   = 1'h0;
    case (op_in)
      exec_pkg::OP_ADD:
      begin
        result_out = sum[7:0];
        carry_out  = sum[8];
        half_out   = low_sum[4];
      end
      exec_pkg::OP_AND:   result_out = acc_in & operand_in;
      exec_pkg::OP_ERASE: result_out = operand_in & ~(8'h01 << bitpos_in);
      default:            result_out = operand_in;
    endcase
    zero_out = (result_out == 8'h00);
  end

endmodule // exec_alu

// ===== test/exec_props.sv
// Property checker for the add, and and bit-erase executor
module exec_props (
  input wire logic               mclk_in,
  input wire logic               rst_n_in,
  input wire logic               instr_valid_in,
  input wire logic [13:0]        instr_word_in,
  input wire logic [7:0]         file_rd_data_in,
  input wire logic [7:0]         port_a_pins_in,
  input wire logic               prescaler_on_timer_in,
  input wire logic [7:0]         acc_out,
  input wire exec_pkg::flags_t   flags_out,
  input wire exec_pkg::file_wr_t file_wr_out,
  input wire logic               prescaler_clr_out,
  input wire logic               done_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic       np, ad, an, er, d;
  logic [8:0] sum;
  logic [7:0] prod, clr, pclr;
  // Port addresses take pin levels, so they are left out here
  assign np   = instr_valid_in && !(instr_word_in[6:0] inside {7'h05, 7'h06});
  assign ad   = np && instr_word_in[13:8] == 6'h07;
  assign an   = np && instr_word_in[13:8] == 6'h05;
  assign er   = np && instr_word_in[13:10] == 4'h4;
  assign d    = instr_word_in[7];
  assign sum  = {1'h0, acc_out} + {1'h0, file_rd_data_in};
  assign prod = acc_out & file_rd_data_in;
  assign clr  = file_rd_data_in & ~(8'h01 << instr_word_in[9:7]);
  assign pclr = port_a_pins_in & ~(8'h01 << instr_word_in[9:7]);
  a_add_to_acc: assert property (ad && !d |=> acc_out == $past(sum[7:0]) && done_out
    && flags_out.carry == $past(sum[8])) else $error("add to accumulator wrong");
  a_add_to_file: assert property (ad && d |=> file_wr_out.wr_en && $stable(acc_out)
    && file_wr_out.data == $past(sum[7:0])) else $error("add to file wrong");
  a_and_zero_only: assert property (an |=> flags_out.zero == ($past(prod) == 8'h00)
    && flags_out.carry == $past(flags_out.carry)) else $error("and flags wrong");
  a_and_to_acc: assert property (an && !d |=> acc_out == $past(prod)
    && !file_wr_out.wr_en) else $error("and to accumulator wrong");
  a_erase_bit: assert property (er |=> file_wr_out.wr_en && file_wr_out.data == $past(clr)
    && $stable(flags_out)) else $error("bit erase wrong");
  a_port_pins: assert property ($stable(port_a_pins_in)[*3] ##0 instr_valid_in
    && instr_word_in == 14'h1005 |=> file_wr_out.data == $past(pclr)) else $error("port operand");
  a_timer_clear: assert property ((er || (ad || an) && d) && instr_word_in[6:0] == 7'h01
    && prescaler_on_timer_in |=> prescaler_clr_out) else $error("prescaler not cleared");
  c_add_file: cover property (ad && d);
  c_and_acc: cover property (an && !d);
  c_erase: cover property (er ##1 done_out);
endmodule // exec_props

bind add_and_bitclear_exec exec_props i_exec_props (.*);

// ===== test/add_and_bitclear_exec_tb_top.sv
// Self-checking bench for the add, and and bit-erase executor
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module add_and_bitclear_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in = 0, rst_n_in = 0, instr_valid_in = 0, prescaler_on_timer_in = 0;
  logic [13:0] instr_word_in = 14'h0000;
  logic [7:0] file_rd_data_in = 8'h00, port_a_pins_in = 8'hA5, port_b_pins_in = 8'h3C;
  logic [7:0] acc_out;
  exec_pkg::flags_t flags_out;
  exec_pkg::file_wr_t file_wr_out;
  logic prescaler_clr_out, done_out, unsupported_out;
  int n_fail = 0, check_count = 0;
  add_and_bitclear_exec i_add_and_bitclear_exec (.*);
  always #20 mclk_in = ~mclk_in;
  task run(input logic [13:0] w, input logic [7:0] f);
    @(posedge mclk_in);
    instr_valid_in <= 1'h1;
    instr_word_in <= w;
    file_rd_data_in <= f;
    @(posedge mclk_in);
    instr_valid_in <= 1'h0;
    #1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #50us;
    n_fail++;
    stop_test;
  end
  initial
  begin
    repeat (5) @(posedge mclk_in);
    rst_n_in <= 1'h1;
    #1;
    `CHK({acc_out, flags_out}, 11'h000)
    run(14'h0720, 8'h17);
    run(14'h0720, 8'hC2);
    `CHK({acc_out, flags_out}, {8'hD9, 3'h0})
    run(14'h07A0, 8'hF0);
    `CHK({file_wr_out, acc_out, flags_out}, {8'hA0, 8'hC9, 8'hD9, 3'h4})
    run(14'h0720, 8'h27);
    `CHK({acc_out, flags_out, done_out}, {8'h00, 3'h7, 1'h1})
    $display("add test done");
    for (int b = 0; b < 8; b++)
    begin
      run({4'h4, b[2:0], 7'h30}, 8'hFF);
      `CHK({file_wr_out, flags_out}, {8'hB0, ~(8'h01 << b), 3'h7})
    end
    $display("erase test done");
    run(14'h0520, 8'hFF);
    `CHK({acc_out, flags_out, file_wr_out.wr_en}, {8'h00, 3'h7, 1'h0})
    run(14'h0720, 8'h17);
    @(posedge mclk_in);
    prescaler_on_timer_in <= 1'h1;
    run(14'h0581, 8'hC2);
    `CHK({file_wr_out, acc_out, prescaler_clr_out}, {16'h8102, 8'h17, 1'h1})
    run(14'h0701, 8'h01);
    `CHK(prescaler_clr_out, 1'h0)
    run(14'h1005, 8'h00);
    `CHK(file_wr_out, 16'h85A4)
    run(14'h0586, 8'h00);
    `CHK(file_wr_out, 16'h8618)
    run(14'h3FFF, 8'h00);
    `CHK({unsupported_out, done_out, file_wr_out.wr_en}, 3'h4)
    $display("and, timer and port test done");
    stop_test;
  end
endmodule // add_and_bitclear_exec_tb_top
